/* cbp_pkg.sv */
/*
 * Shared constants, state codes and carrier types for the clock buffer
 * power and output control block.
 * Assumes a single 10 MHz clock and a synchronous active-high reset.
 */
`default_nettype none

package cbp_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register map (byte addresses, one aligned 32-bit word each)
	localparam int             ADDR_W      = 8;
	localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h00;	// Read-only block state
	localparam logic [ADDR_W-1:0] REG_ENABLE  = 8'h04;	// Per-output enable bits
	localparam logic [ADDR_W-1:0] REG_ADDRSEL = 8'h08;	// Latched address straps

	// Status register field positions
	localparam int ST_FREQ_BIT  = 0;	// 1 = 100 MHz, 0 = 133 MHz
	localparam int ST_MODE_LSB  = 1;	// Two-bit PLL mode readback
	localparam int ST_STATE_LSB = 8;	// One-hot power-up state
	localparam int ST_LOCK_BIT  = 16;
	localparam int ST_SEEN_BIT  = 17;	// Power-good has been high once
	localparam int ST_TRI_BIT   = 18;	// Outputs parked by powerdown

	// Outputs that follow the output-enable pin
	localparam int GATED_LO = 5;
	localparam int GATED_HI = 12;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int DELAY_MIN_NS  = 100000;	// 0.1 ms supply settle delay
	localparam int DELAY_CYC     = (DELAY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DELAY_W       = $clog2(DELAY_CYC + 1);
	localparam int PD_EDGES      = 2;	// Complement-clock rising edges seen low

	////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [4:0] {
		ST_OFF   = 5'h01,
		ST_DELAY = 5'h02,
		ST_WAIT  = 5'h04,
		ST_RUN   = 5'h08,
		ST_PDOWN = 5'h10
	} cbp_state_e;

	// Asynchronous inputs, carried together through the synchroniser
	typedef struct packed {
		logic       pwrGood;
		logic       oeN;
		logic       comp;
		logic       freq;
		logic [1:0] bwSel;
		logic [3:0] addrSel;
		logic       supply;
		logic       clkValid;
		logic       lock;
	} cbp_pins_s;

	// Configuration captured at the first power-good assertion
	typedef struct packed {
		logic       freq;
		logic [1:0] pllMode;
		logic [3:0] addrSel;
	} cbp_cfg_s;

	localparam cbp_cfg_s CFG_RESET = '0;

endpackage : cbp_pkg

`default_nettype wire

/* cbp_power_ctrl.sv */
/*
 * Power-up sequencer, powerdown handling and output gating of a
 * differential clock fanout buffer, with an AXI4-Lite register slave.
 * Assumes supply-good, input-clock-valid and PLL-lock come from analog
 * circuitry; all pins are asynchronous and are synchronised here.
 */
// The AXI4-Lite slave port and the register addresses were decided locally.
// Overview of operation
// - Power pin low: all outputs and feedback high impedance, PLL off.
// - Enable bit 0 tri-states that output; feedback and PLL keep running.
// - Enable bit 1 and output-enable pin 0 drive every output.
// - Enable bit 1 and output-enable pin 1 tri-state outputs 5 to 12 only.
// - Frequency and address straps captured when power-good first rises.
// - After first assertion the pin acts as active-low asynchronous powerdown.
// - Low on two complement-clock rises, tri-state at the next falling edge.
// - Supply good leaves power-off and waits at least 0.1 ms.
// - After the delay, wait for valid input clock and power pin high.
// - Enter operating state and enable outputs only on PLL lock.
// - Power-on to outputs active stays under 1.8 ms with clock present.
// - Without input clock, outputs stay disabled until clock and lock.
// - Per-output read-write enable bits reset to 1; 0 forces high impedance.
// - Latched frequency select readable: 1 is 100 MHz, 0 is 133 MHz.
`default_nettype none

module cbp_power_ctrl #(
	parameter int NUM_OUTPUTS = 19
) (
	input  wire logic                        mclk,                   // 10 MHz clock
	input  wire logic                        rst,                    // Sync reset
	// Pins and analog indications
	input  wire logic                        power_good_in,          // Power-good / powerdown_n
	input  wire logic                        outputEnablePin_n,      // Gates outputs 5..12
	input  wire logic                        diff_clock_out_comp,    // Complement output clock
	input  wire logic                        freq_select,            // Frequency strap
	input  wire logic [1:0]                  pll_bandwidth_select,   // PLL mode strap code
	input  wire logic [3:0]                  bus_addr_select,        // Address straps
	input  wire logic                        supplyGood,             // Supply above minimum
	input  wire logic                        inputClockValid,        // Reference clock seen
	input  wire logic                        pllLocked,              // PLL lock
	output logic                             pllEnable,              // PLL on
	output logic [NUM_OUTPUTS-1:0]           diffOutEnable_n,        // Low drives output
	output logic                             feedbackOutEnable_n,    // Low drives feedback
	// AXI4-Lite slave
	input  wire logic [cbp_pkg::ADDR_W-1:0]  s_axi_awaddr,           // Write address
	input  wire logic                        s_axi_awvalid,          // Write address valid
	output logic                             s_axi_awready,          // Write address ready
	input  wire logic [31:0]                 s_axi_wdata,            // Write data
	input  wire logic [3:0]                  s_axi_wstrb,            // Byte lanes
	input  wire logic                        s_axi_wvalid,           // Write data valid
	output logic                             s_axi_wready,           // Write data ready
	output logic [1:0]                       s_axi_bresp,            // Write response
	output logic                             s_axi_bvalid,           // Response valid
	input  wire logic                        s_axi_bready,           // Response ready
	input  wire logic [cbp_pkg::ADDR_W-1:0]  s_axi_araddr,           // Read address
	input  wire logic                        s_axi_arvalid,          // Read address valid
	output logic                             s_axi_arready,          // Read address ready
	output logic [31:0]                      s_axi_rdata,            // Read data
	output logic [1:0]                       s_axi_rresp,            // Read response
	output logic                             s_axi_rvalid,           // Read data valid
	input  wire logic                        s_axi_rready            // Read ready
);

	////////////////////////////////////////////////////////////////////////////
	// Address decode, shared by the write and read paths
	function automatic logic [1:0] decodeAddr(input logic [cbp_pkg::ADDR_W-1:0] a);
		unique case (a)
			cbp_pkg::REG_STATUS:  decodeAddr = 2'h1;
			cbp_pkg::REG_ENABLE:  decodeAddr = 2'h2;
			cbp_pkg::REG_ADDRSEL: decodeAddr = 2'h3;
			default:              decodeAddr = 2'h0;
		endcase
	endfunction : decodeAddr

	////////////////////////////////////////////////////////////////////////////
	// Two-flop synchroniser; pins and analog levels are all asynchronous
	cbp_pkg::cbp_pins_s pinsRaw;
	cbp_pkg::cbp_pins_s syncA;
	cbp_pkg::cbp_pins_s pins;
	logic               compPrev;

	assign pinsRaw = '{pwrGood: power_good_in, oeN: outputEnablePin_n,
		comp: diff_clock_out_comp, freq: freq_select, bwSel: pll_bandwidth_select,
		addrSel: bus_addr_select, supply: supplyGood, clkValid: inputClockValid,
		lock: pllLocked};

	// Only the second stage is read by logic
	always_ff @(posedge mclk) begin
		if (rst) begin
			syncA    <= '0;
			pins     <= '0;
			compPrev <= 1'b0;
		end else begin
			syncA    <= pinsRaw;
			pins     <= syncA;
			compPrev <= pins.comp;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer, strap latch, powerdown edge counter and output gating
	cbp_pkg::cbp_state_e            state,     next_state;
	logic [cbp_pkg::DELAY_W-1:0]    delayCnt,  next_delayCnt;
	logic [1:0]                     pdCnt,     next_pdCnt;
	logic                           seenFirst, next_seenFirst;
	logic                           pwrPrev,   next_pwrPrev;
	cbp_pkg::cbp_cfg_s              cfg,       next_cfg;
	logic [NUM_OUTPUTS-1:0]         enableBits, next_enableBits;
	logic [NUM_OUTPUTS-1:0]         next_diffOutEnable_n;
	logic                           next_feedbackOutEnable_n;
	logic                           next_pllEnable;
	logic                           compRise;
	logic                           compFall;
	logic                           pdFire;
	logic                           firstAssert;
	logic                           regWrite;
	logic [NUM_OUTPUTS-1:0]         regWriteVal;

	assign compRise    = pins.comp & ~compPrev;
	assign compFall    = ~pins.comp & compPrev;
	assign pdFire      = (pdCnt == 2'(cbp_pkg::PD_EDGES)) && compFall;
	assign firstAssert = pins.pwrGood && !pwrPrev && !seenFirst;

	// Next-state logic; a supply loss returns to power-off from anywhere
	always_comb begin
		next_state      = state;
		next_delayCnt   = delayCnt;
		next_pdCnt      = pdCnt;
		next_seenFirst  = seenFirst;
		next_pwrPrev    = pins.pwrGood;
		next_cfg        = cfg;
		next_enableBits = regWrite ? regWriteVal : enableBits;
		// Straps are frozen at the first assertion only
		if (firstAssert) begin
			next_seenFirst = 1'b1;
			next_cfg       = '{freq: pins.freq, pllMode: pins.bwSel, addrSel: pins.addrSel};
		end
		unique case (state)
			cbp_pkg::ST_OFF: begin
				next_delayCnt = '0;
				if (pins.supply) next_state = cbp_pkg::ST_DELAY;
			end
			cbp_pkg::ST_DELAY: begin
				// Minimum of the delay window keeps total power-up latency short
				next_delayCnt = delayCnt + 1'b1;
				if (delayCnt == cbp_pkg::DELAY_W'(cbp_pkg::DELAY_CYC - 1))
					next_state = cbp_pkg::ST_WAIT;
			end
			cbp_pkg::ST_WAIT: begin
				// Lock is only trusted while clock and power pin are good
				if (pins.clkValid && pins.pwrGood && pins.lock)
					next_state = cbp_pkg::ST_RUN;
			end
			cbp_pkg::ST_RUN: begin
				// Count complement rises with the pin low; any high resets
				if (pins.pwrGood) next_pdCnt = '0;
				else if (compRise && pdCnt != 2'(cbp_pkg::PD_EDGES))
					next_pdCnt = pdCnt + 1'b1;
				if (pdFire) next_state = cbp_pkg::ST_PDOWN;
			end
			cbp_pkg::ST_PDOWN: begin
				next_pdCnt = '0;
				if (pins.pwrGood) next_state = cbp_pkg::ST_WAIT;
			end
		endcase
		if (!pins.supply) begin
			next_state     = cbp_pkg::ST_OFF;
			next_seenFirst = 1'b0;
			next_pdCnt     = '0;
		end
		// Outputs follow the current state; enable bit 0, or pin high for outputs 5..12, tri-states
		next_pllEnable           = (state == cbp_pkg::ST_WAIT && pins.pwrGood)
			|| state == cbp_pkg::ST_RUN;
		next_feedbackOutEnable_n = state != cbp_pkg::ST_RUN;
		for (int i = 0; i < NUM_OUTPUTS; i++) begin
			next_diffOutEnable_n[i] = !(state == cbp_pkg::ST_RUN && enableBits[i]
				&& !(pins.oeN && i >= cbp_pkg::GATED_LO
				&& i <= cbp_pkg::GATED_HI));
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state               <= cbp_pkg::ST_OFF;
			delayCnt            <= '0;
			pdCnt               <= '0;
			seenFirst           <= 1'b0;
			pwrPrev             <= 1'b0;
			cfg                 <= cbp_pkg::CFG_RESET;
			enableBits          <= '1;
			diffOutEnable_n     <= '1;
			feedbackOutEnable_n <= 1'b1;
			pllEnable           <= 1'b0;
		end else begin
			state               <= next_state;
			delayCnt            <= next_delayCnt;
			pdCnt               <= next_pdCnt;
			seenFirst           <= next_seenFirst;
			pwrPrev             <= next_pwrPrev;
			cfg                 <= next_cfg;
			enableBits          <= next_enableBits;
			diffOutEnable_n     <= next_diffOutEnable_n;
			feedbackOutEnable_n <= next_feedbackOutEnable_n;
			pllEnable           <= next_pllEnable;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave: address and data held until both arrive
	logic                       awHeld, next_awHeld;
	logic                       wHeld,  next_wHeld;
	logic [cbp_pkg::ADDR_W-1:0] awAddr, next_awAddr;
	logic [31:0]                wData,  next_wData;
	logic [3:0]                 wStrb,  next_wStrb;
	logic                       next_bvalid;
	logic [1:0]                 next_bresp;
	logic                       next_rvalid;
	logic [1:0]                 next_rresp;
	logic [31:0]                next_rdata;
	logic [31:0]                statusWord;
	logic [31:0]                mergedEnable;

	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready  = !wHeld && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign regWrite      = awHeld && wHeld && !s_axi_bvalid
		&& decodeAddr(awAddr) == 2'h2;

	// Byte lanes merge into the enable word; bits above the outputs drop
	always_comb begin
		mergedEnable = 32'(enableBits);
		for (int b = 0; b < 4; b++)
			if (wStrb[b]) mergedEnable[b*8 +: 8] = wData[b*8 +: 8];
		regWriteVal = mergedEnable[NUM_OUTPUTS-1:0];
	end

	// Status shows the latched frequency and PLL mode straps and the sequencer's own state
	always_comb begin
		statusWord = '0;
		statusWord[cbp_pkg::ST_FREQ_BIT] = cfg.freq;
		statusWord[cbp_pkg::ST_MODE_LSB +: 2] = cfg.pllMode;
		statusWord[cbp_pkg::ST_STATE_LSB +: 5] = state;
		statusWord[cbp_pkg::ST_LOCK_BIT] = pins.lock;
		statusWord[cbp_pkg::ST_SEEN_BIT] = seenFirst;
		statusWord[cbp_pkg::ST_TRI_BIT] = state == cbp_pkg::ST_PDOWN;
	end

	always_comb begin
		next_awHeld = awHeld;
		next_wHeld  = wHeld;
		next_awAddr = awAddr;
		next_wData  = wData;
		next_wStrb  = wStrb;
		next_bvalid = s_axi_bvalid;
		next_bresp  = s_axi_bresp;
		next_rvalid = s_axi_rvalid;
		next_rresp  = s_axi_rresp;
		next_rdata  = s_axi_rdata;
		if (s_axi_awvalid && s_axi_awready) begin
			next_awHeld = 1'b1;
			next_awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_wHeld = 1'b1;
			next_wData = s_axi_wdata;
			next_wStrb = s_axi_wstrb;
		end
		// Read-only registers accept writes silently; unmapped gets SLVERR
		if (awHeld && wHeld && !s_axi_bvalid) begin
			next_awHeld = 1'b0;
			next_wHeld  = 1'b0;
			next_bvalid = 1'b1;
			next_bresp  = decodeAddr(awAddr) == 2'h0 ? cbp_pkg::RESP_SLVERR
				: cbp_pkg::RESP_OKAY;
		end else if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp  = cbp_pkg::RESP_OKAY;
			unique case (decodeAddr(s_axi_araddr))
				2'h1: next_rdata = statusWord;
				2'h2: next_rdata = 32'(enableBits);
				2'h3: next_rdata = 32'(cfg.addrSel);
				default: begin
					next_rdata = '0;
					next_rresp = cbp_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			awHeld       <= 1'b0;
			wHeld        <= 1'b0;
			awAddr       <= '0;
			wData        <= '0;
			wStrb        <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= cbp_pkg::RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= cbp_pkg::RESP_OKAY;
			s_axi_rdata  <= '0;
		end else begin
			awHeld       <= next_awHeld;
			wHeld        <= next_wHeld;
			awAddr       <= next_awAddr;
			wData        <= next_wData;
			wStrb        <= next_wStrb;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp  <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rresp  <= next_rresp;
			s_axi_rdata  <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	property p_pdownOff;
		@(posedge mclk) disable iff (rst)
		state == cbp_pkg::ST_PDOWN |=> (&diffOutEnable_n) && feedbackOutEnable_n && !pllEnable;
	endproperty
	a_pdownOff: assert property (p_pdownOff) else $error("outputs live in powerdown");

	property p_bitOff;
		@(posedge mclk) disable iff (rst)
		state == cbp_pkg::ST_RUN && !enableBits[0]
			|=> diffOutEnable_n[0] && !feedbackOutEnable_n && pllEnable;
	endproperty
	a_bitOff: assert property (p_bitOff) else $error("disabled output driven");

	property p_allOn;
		@(posedge mclk) disable iff (rst)
		state == cbp_pkg::ST_RUN && enableBits[5] && !pins.oeN
			|=> !diffOutEnable_n[5] && !feedbackOutEnable_n;
	endproperty
	a_allOn: assert property (p_allOn) else $error("enabled output not driven");

	property p_pinGroup;
		@(posedge mclk) disable iff (rst)
		state == cbp_pkg::ST_RUN && enableBits[12] && enableBits[13] && pins.oeN
			|=> diffOutEnable_n[12] && !diffOutEnable_n[13];
	endproperty
	a_pinGroup: assert property (p_pinGroup) else $error("pin gating wrong group");

	property p_latch;
		@(posedge mclk) disable iff (rst)
		firstAssert && pins.supply |=> cfg.freq == $past(pins.freq) && seenFirst;
	endproperty
	a_latch: assert property (p_latch) else $error("straps not captured");

	property p_pdSeq;
		@(posedge mclk) disable iff (rst)
		state == cbp_pkg::ST_RUN && pdFire && pins.supply
			|=> state == cbp_pkg::ST_PDOWN ##1 &diffOutEnable_n;
	endproperty
	a_pdSeq: assert property (p_pdSeq) else $error("powerdown not taken");

	property p_delayHold;
		@(posedge mclk) disable iff (rst)
		state == cbp_pkg::ST_DELAY && pins.supply
			&& delayCnt != cbp_pkg::DELAY_W'(cbp_pkg::DELAY_CYC - 1)
			|=> state == cbp_pkg::ST_DELAY;
	endproperty
	a_delayHold: assert property (p_delayHold) else $error("delay cut short");

	property p_waitHold;
		@(posedge mclk) disable iff (rst)
		state == cbp_pkg::ST_WAIT && pins.supply && !(pins.clkValid && pins.pwrGood)
			|=> state == cbp_pkg::ST_WAIT;
	endproperty
	a_waitHold: assert property (p_waitHold) else $error("left wait early");

	property p_lockEntry;
		@(posedge mclk) disable iff (rst)
		$rose(state == cbp_pkg::ST_RUN) |-> $past(pins.lock);
	endproperty
	a_lockEntry: assert property (p_lockEntry) else $error("run without lock");

	property p_notRunOff;
		@(posedge mclk) disable iff (rst)
		state != cbp_pkg::ST_RUN |=> &diffOutEnable_n;
	endproperty
	a_notRunOff: assert property (p_notRunOff) else $error("output before run");

	property p_enReset;
		@(posedge mclk) rst |=> &enableBits;
	endproperty
	a_enReset: assert property (p_enReset) else $error("enable reset wrong");

	c_run:   cover property (@(posedge mclk) disable iff (rst) $rose(state == cbp_pkg::ST_RUN));
	c_pdown: cover property (@(posedge mclk) disable iff (rst) state == cbp_pkg::ST_PDOWN);
	c_write: cover property (@(posedge mclk) disable iff (rst) regWrite);

endmodule : cbp_power_ctrl

`default_nettype wire

/* cbp_platform_model.sv */
/*
 * Platform power sequencing model: supply, power pin, straps, reference
 * indications and the complement output clock seen by the control block.
 * Assumes the bench calls its tasks from one process, clocked by mclk.
 */
`default_nettype none

module cbp_platform_model (
	input  wire logic mclk,     // Bench clock
	output logic      pwrGood,  // Power-good / powerdown_n pin
	output logic      supply,   // Supply above minimum
	output logic      clkValid, // Reference clock present
	output logic      lock,     // PLL lock indication
	output logic      freq,     // Frequency strap
	output logic [1:0] bwSel,   // Bandwidth strap
	output logic [3:0] addrSel, // Address straps
	output logic      comp      // Complement output clock
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] compCnt;

	////////////////////////////////////////////////////////////////////////
	// Complement clock, 20 mclk period; it stands still without a reference
	always @(posedge mclk) begin
		compCnt <= (compCnt == 4'h9) ? 4'h0 : compCnt + 4'h1;
		if (compCnt == 4'h9 && clkValid) begin
			comp <= ~comp;
		end
	end

	// Pin held low from time zero so no strap is latched early
	initial begin
		pwrGood = 1'b0;
		{supply, clkValid, lock, comp, compCnt} = '0;
		{freq, bwSel, addrSel} = '0;
	end

	// Straps first, then supply, pin raised only once the supply is good
	task automatic power_on(input logic f, input logic [1:0] b, input logic [3:0] a,
			input logic cv);
		@(posedge mclk);
		{freq, bwSel, addrSel} <= {f, b, a};
		@(posedge mclk);
		supply <= 1'b1;
		{clkValid, lock} <= {cv, cv};
		@(posedge mclk);
		pwrGood <= 1'b1;
	endtask : power_on

	task automatic set_ref(input logic cv);
		@(posedge mclk);
		{clkValid, lock} <= {cv, cv};
	endtask : set_ref

	task automatic set_pin(input logic v);
		@(posedge mclk);
		pwrGood <= v;
	endtask : set_pin

	// Powerdown is asserted before the reference and supply go away
	task automatic power_off;
		set_pin(1'b0);
		@(posedge mclk);
		{clkValid, lock, supply} <= 3'h0;
	endtask : power_off
endmodule : cbp_platform_model

`default_nettype wire

/* clock_buffer_power_output_control_tb.sv */
/*
 * Self-checking bench for the power and output control block: power-up,
 * register bus, output gating and the glitch-free powerdown sequence.
 * Assumes the platform model above and the block's default of 19 outputs.
 */
`default_nettype none

module clock_buffer_power_output_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk, rst, oePin_n, pllEnable, fbEn_n, pg, sup, cv, lk, fr, comp;
	logic [1:0]  bw, bresp, rresp;
	logic [3:0]  as, wstrb;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [18:0] diffEn_n, en;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, f, oe;
	logic [1:0]  r, b;
	logic [3:0]  a;
	int          seed, n, miscompares, testsRun;

	cbp_power_ctrl u_dut (.mclk(mclk), .rst(rst), .power_good_in(pg),
		.outputEnablePin_n(oePin_n), .diff_clock_out_comp(comp), .freq_select(fr),
		.pll_bandwidth_select(bw), .bus_addr_select(as), .supplyGood(sup),
		.inputClockValid(cv), .pllLocked(lk), .pllEnable(pllEnable),
		.diffOutEnable_n(diffEn_n), .feedbackOutEnable_n(fbEn_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	cbp_platform_model u_plat (.mclk(mclk), .pwrGood(pg), .supply(sup), .clkValid(cv),
		.lock(lk), .freq(fr), .bwSel(bw), .addrSel(as), .comp(comp));

	////////////////////////////////////////////////////////////////////////
	// Clock, 100 ns period
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic complete_run;
		$display("tests_run=%0d miscompares=%0d", testsRun, miscompares);
		if (miscompares == 0 && testsRun > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] exp, input logic [31:0] got);
		testsRun++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : check

	// Settle 1 ns past the edge so registered outputs have landed
	task automatic cyc(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask : cyc

	// A bus or sequencer wait that never ends is a failure, not a hang
	task automatic stuck(input int k);
		if (k >= 20000) begin
			miscompares++;
			complete_run();
		end
	endtask : stuck

	task automatic axi_write(input logic [7:0] ad, input logic [31:0] dat,
			output logic [1:0] resp);
		int k;
		@(posedge mclk);
		{awaddr, wdata, wstrb} <= {ad, dat, 4'hF};
		{awvalid, wvalid, bready} <= 3'h7;
		for (k = 0; k < 20000; k++) begin
			@(posedge mclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		resp = bresp;
		bready <= 1'b0;
		stuck(k);
	endtask : axi_write

	task automatic axi_read(input logic [7:0] ad, output logic [31:0] dat,
			output logic [1:0] resp);
		int k;
		@(posedge mclk);
		araddr <= ad;
		{arvalid, rready} <= 2'h3;
		for (k = 0; k < 20000; k++) begin
			@(posedge mclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		{dat, resp} = {rdata, rresp};
		rready <= 1'b0;
		stuck(k);
	endtask : axi_read

	task automatic wait_fb(output int k);
		for (k = 0; k < 20000; k++) begin
			cyc(1);
			if (fbEn_n === 1'b0) break;
		end
		stuck(k);
	endtask : wait_fb

	// Expected enables: bit low drives, 5..12 also follow the pin
	function automatic logic [18:0] exp_gate(input logic [18:0] e, input logic o);
		logic [18:0] g;
		for (int i = 0; i < 19; i++) begin
			g[i] = ~(e[i] & ~(o && i >= cbp_pkg::GATED_LO && i <= cbp_pkg::GATED_HI));
		end
		return g;
	endfunction : exp_gate

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, oePin_n} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{seed, miscompares, testsRun, rst} = {32'd46, 32'd0, 32'd0, 1'b1};
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		cyc(1);
		check({11'h0, diffEn_n, fbEn_n, pllEnable}, {11'h0, 19'h7FFFF, 2'h2});
		axi_read(cbp_pkg::REG_ENABLE, d, r);
		check(d, 32'h0007FFFF);
		axi_read(cbp_pkg::REG_STATUS, d, r);
		check({27'h0, d[12:8]}, 32'h01);
		axi_write(8'h40, 32'h0, r);
		check({30'h0, r}, {30'h0, cbp_pkg::RESP_SLVERR});
		axi_read(8'h40, d, r);
		check({d[29:0], r}, {30'h0, cbp_pkg::RESP_SLVERR});
		{f, b, a} = 7'({$random(seed)} % 128);
		u_plat.power_on(f, b, a, 1'b1);
		wait_fb(n);
		check({31'h0, n + 1 >= cbp_pkg::DELAY_CYC && n < 18000}, 32'h1);
		axi_read(cbp_pkg::REG_STATUS, d, r);
		check({26'h0, d[12:8], d[0]}, {26'h0, 5'h08, f});
		axi_read(cbp_pkg::REG_ADDRSEL, d, r);
		check(d, {28'h0, a});
		// Enable bits and the pin, corners first, then random
		for (int i = 0; i < 8; i++) begin
			en = (i == 0) ? 19'h7FFFF : (i == 1) ? 19'h0 : 19'($random(seed));
			oe = (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : 1'($random(seed));
			axi_write(cbp_pkg::REG_ENABLE, {13'h0, en}, r);
			oePin_n <= oe;
			check({30'h0, r}, {30'h0, cbp_pkg::RESP_OKAY});
			cyc(6);
			check({13'h0, diffEn_n}, {13'h0, exp_gate(en, oe)});
			check({30'h0, fbEn_n, pllEnable}, 32'h1);
		end
		axi_write(cbp_pkg::REG_ENABLE, 32'h0007FFFF, r);
		oePin_n <= 1'b0;
		// Pin dropped just after a complement rise; two more rises, then a fall
		n = 0;
		while (n < 20000 && comp !== 1'b0) begin
			@(posedge mclk);
			n++;
		end
		while (n < 20000 && comp !== 1'b1) begin
			@(posedge mclk);
			n++;
		end
		stuck(n);
		u_plat.set_pin(1'b0);
		cyc(47);
		check({31'h0, fbEn_n}, 32'h0);
		cyc(17);
		check({11'h0, diffEn_n, fbEn_n, pllEnable}, {11'h0, 19'h7FFFF, 2'h2});
		axi_read(cbp_pkg::REG_STATUS, d, r);
		check({26'h0, d[12:8], d[18]}, {26'h0, 5'h10, 1'b1});
		u_plat.set_pin(1'b1);
		wait_fb(n);
		cyc(2);
		check({13'h0, diffEn_n}, 32'h0);
		// Supply cycled, then power-up with no reference clock
		u_plat.power_off();
		cyc(4);
		check({31'h0, fbEn_n}, 32'h1);
		u_plat.power_on(~f, b, ~a, 1'b0);
		cyc(1200);
		check({12'h0, diffEn_n, fbEn_n}, {12'h0, 20'hFFFFF});
		u_plat.set_ref(1'b1);
		wait_fb(n);
		axi_read(cbp_pkg::REG_ADDRSEL, d, r);
		check(d, {28'h0, ~a});
		complete_run();
	end
endmodule : clock_buffer_power_output_control_tb

`default_nettype wire
